// ==== logic/dam_defs.svh ====
/*
 Constants of the data memory address modifier: register offsets,
 flag bit positions, reset values and address field positions.
 Assumes inclusion by bare name from the design file.
*/
`ifndef DAM_DEFS_SVH
`define DAM_DEFS_SVH

`define DAM_OFS_IDX_UPPER 3'h0
`define DAM_OFS_IDX_MIDDLE 3'h1
`define DAM_OFS_IDX_LOWER 3'h2
`define DAM_OFS_FLAGS 3'h3

`define DAM_RPE_BIT 3
`define DAM_IDXEN_BIT 0
`define DAM_MODE_LSB 1
`define DAM_MODE_MSB 2

`define DAM_NIB_RESET 4'h0
`define DAM_FLAG_RESET 1'b0
`define DAM_READ_ZERO 4'h0
`define DAM_PTR_BANK 4'h0

`define DAM_BANK_MSB 10
`define DAM_BANK_LSB 7
`define DAM_ROW_MSB 6
`define DAM_ROW_LSB 4
`define DAM_COL_MSB 3
`define DAM_COL_LSB 0
`define DAM_IDXU_MSB 2
`define DAM_IDXU_LSB 0
`define DAM_PTRLO_ROW_MSB 2
`define DAM_PTRLO_ROW_LSB 0

`endif

// ==== logic/dam_pkg.sv ====
/*
 Types of the data memory address modifier: operations, modes,
 request and result carriers.
 Assumes a decoder on the same clock that fills the request.
*/
package dam_pkg;

    localparam int DAM_AW = 11;

    typedef enum logic [1:0] {
        DAM_OP_DATA,
        DAM_OP_ADD,
        DAM_OP_IND_STORE,
        DAM_OP_IND_LOAD
    } dam_op_t;

    typedef enum logic [1:0] {
        DAM_MODE_NONE,
        DAM_MODE_DIAGONAL,
        DAM_MODE_INDEX,
        DAM_MODE_BOTH
    } dam_mode_t;

    typedef struct packed {
        logic valid;
        dam_op_t op;
        logic [DAM_AW-1:0] m_addr;
        logic [DAM_AW-1:0] r_addr;
        logic [3:0] r_val;
        logic [3:0] m_val;
    } dam_req_t;

    typedef struct packed {
        logic valid;
        dam_op_t op;
        logic [DAM_AW-1:0] direct_addr;
        logic [DAM_AW-1:0] indirect_addr;
        logic [DAM_AW-1:0] src_addr;
        logic [DAM_AW-1:0] dst_addr;
        logic [3:0] sum;
        logic carry;
        logic wr_en;
    } dam_res_t;

endpackage : dam_pkg

// ==== logic/dam_modifier.sv ====
/*
 Data memory address modifier of a 4-bit core: index register, row
 pointer, mode flags and effective address generation.
 Assumes requests from the decoder on mclk, register values already read
 by the caller, and a plain one-cycle register port from the core.
*/
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "dam_defs.svh"
`default_nettype none

module dam_modifier (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] bus_addr,
    input wire logic [3:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [3:0] bus_rdata,
    input wire dam_pkg::dam_req_t req,
    output dam_pkg::dam_res_t res,
    output logic row_pointer_enable_flag,
    output logic index_enable_flag
);

    logic [3:0] row_pointer_upper_reg;
    logic [3:0] row_pointer_lower_reg;
    logic [3:0] index_lower_field_reg;
    logic index_enable_reg;
    logic [3:0] rdata_reg;
    dam_pkg::dam_res_t res_reg;
    dam_pkg::dam_res_t res_next;
    logic [dam_pkg::DAM_AW-1:0] index_reg;
    logic [2:0] index_upper_field;
    logic [3:0] index_middle_field;
    logic [3:0] ptr_bank;
    logic [2:0] ptr_row;
    dam_pkg::dam_mode_t mode;
    logic [3:0] rdata_next;
    logic [dam_pkg::DAM_AW-1:0] m_or_index;

    // Mode decode, shared by the datapath and the flag readback
    function automatic dam_pkg::dam_mode_t decode_mode(input logic rpe,
                                                       input logic idx_en);
        dam_pkg::dam_mode_t m;
        m = dam_pkg::DAM_MODE_NONE;
        case ({idx_en, rpe})
            2'h0: m = dam_pkg::DAM_MODE_NONE;
            2'h1: m = dam_pkg::DAM_MODE_DIAGONAL;
            2'h2: m = dam_pkg::DAM_MODE_INDEX;
            default: m = dam_pkg::DAM_MODE_BOTH;
        endcase
        return m;
    endfunction : decode_mode

    function automatic logic is_transfer(input dam_pkg::dam_op_t op);
        return (op == dam_pkg::DAM_OP_IND_STORE) ||
               (op == dam_pkg::DAM_OP_IND_LOAD);
    endfunction : is_transfer

    // Upper nibble is shared: top bit enables the pointer, rest is index
    assign row_pointer_enable_flag = row_pointer_upper_reg[`DAM_RPE_BIT];
    assign index_enable_flag = index_enable_reg;
    assign index_upper_field =
        row_pointer_upper_reg[`DAM_IDXU_MSB:`DAM_IDXU_LSB];
    assign index_middle_field = row_pointer_lower_reg;
    assign index_reg = {index_upper_field, index_middle_field,
                        index_lower_field_reg};
    // Pointer bank bits are hardwired low, so upper pointer bits are unused
    assign ptr_bank = `DAM_PTR_BANK;
    assign ptr_row =
        row_pointer_lower_reg[`DAM_PTRLO_ROW_MSB:`DAM_PTRLO_ROW_LSB];
    assign mode = decode_mode(row_pointer_enable_flag, index_enable_reg);
    // One OR serves both the direct and the indirect path in index mode
    assign m_or_index = req.m_addr | index_reg;

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            row_pointer_upper_reg <= `DAM_NIB_RESET;
            row_pointer_lower_reg <= `DAM_NIB_RESET;
            index_lower_field_reg <= `DAM_NIB_RESET;
            index_enable_reg <= `DAM_FLAG_RESET;
        end
        else if (bus_wr)
        begin
            case (bus_addr)
                `DAM_OFS_IDX_UPPER: row_pointer_upper_reg <= bus_wdata;
                `DAM_OFS_IDX_MIDDLE: row_pointer_lower_reg <= bus_wdata;
                `DAM_OFS_IDX_LOWER: index_lower_field_reg <= bus_wdata;
                `DAM_OFS_FLAGS: index_enable_reg <= bus_wdata[`DAM_IDXEN_BIT];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        rdata_next = `DAM_READ_ZERO;
        case (bus_addr)
            `DAM_OFS_IDX_UPPER: rdata_next = row_pointer_upper_reg;
            `DAM_OFS_IDX_MIDDLE: rdata_next = row_pointer_lower_reg;
            `DAM_OFS_IDX_LOWER: rdata_next = index_lower_field_reg;
            `DAM_OFS_FLAGS:
            begin
                rdata_next[`DAM_IDXEN_BIT] = index_enable_reg;
                rdata_next[`DAM_MODE_MSB:`DAM_MODE_LSB] = mode;
            end
            default: rdata_next = `DAM_READ_ZERO;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            rdata_reg <= `DAM_READ_ZERO;
        else
            rdata_reg <= bus_rd ? rdata_next : `DAM_READ_ZERO;
    end

    assign bus_rdata = rdata_reg;

    always_comb
    begin
        res_next = '0;
        res_next.valid = req.valid;
        res_next.op = req.op;
        // Default and forbidden mode both leave the operand untouched
        res_next.direct_addr = req.m_addr;
        // Column of the indirect address comes from r in every mode
        res_next.indirect_addr = {req.m_addr[`DAM_BANK_MSB:`DAM_ROW_LSB],
                                  req.r_val};
        case (mode)
            dam_pkg::DAM_MODE_DIAGONAL:
            begin
                if (is_transfer(req.op))
                    res_next.indirect_addr = {ptr_bank, ptr_row,
                                              req.r_val};
            end
            dam_pkg::DAM_MODE_INDEX:
            begin
                res_next.direct_addr = m_or_index;
                res_next.indirect_addr =
                    {m_or_index[`DAM_BANK_MSB:`DAM_ROW_LSB], req.r_val};
            end
            default: ;
        endcase
        {res_next.carry, res_next.sum} =
            5'(req.r_val) + 5'(req.m_val);
        case (req.op)
            dam_pkg::DAM_OP_ADD:
            begin
                res_next.src_addr = res_next.direct_addr;
                res_next.dst_addr = req.r_addr;
                res_next.wr_en = req.valid;
            end
            dam_pkg::DAM_OP_IND_STORE:
            begin
                res_next.src_addr = res_next.direct_addr;
                res_next.dst_addr = res_next.indirect_addr;
                res_next.wr_en = req.valid;
            end
            dam_pkg::DAM_OP_IND_LOAD:
            begin
                res_next.src_addr = res_next.indirect_addr;
                res_next.dst_addr = res_next.direct_addr;
                res_next.wr_en = req.valid;
            end
            default:
            begin
                res_next.src_addr = res_next.direct_addr;
                res_next.dst_addr = res_next.direct_addr;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            res_reg <= '0;
        else
            res_reg <= res_next;
    end

    assign res = res_reg;

    default clocking dam_cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Checks mostly read the derived index fields; only the diagonal and index row checks read row_pointer_lower_reg

    AST_NONE_PASS: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_NONE
        |=> res.direct_addr == $past(req.m_addr))
        else $error("plain mode modified the direct address");
    AST_ADD_SUM: assert property (
        req.valid && req.op == dam_pkg::DAM_OP_ADD
        |=> res.wr_en && res.dst_addr == $past(req.r_addr) &&
            {res.carry, res.sum} ==
            5'($past(req.r_val)) + 5'($past(req.m_val)))
        else $error("add result or destination wrong");
    AST_STORE_DIR: assert property (
        req.valid && req.op == dam_pkg::DAM_OP_IND_STORE
        |=> res.wr_en && res.src_addr == res.direct_addr &&
            res.dst_addr == res.indirect_addr)
        else $error("indirect store direction wrong");
    AST_LOAD_DIR: assert property (
        req.valid && req.op == dam_pkg::DAM_OP_IND_LOAD
        |=> res.wr_en && res.src_addr == res.indirect_addr &&
            res.dst_addr == res.direct_addr)
        else $error("indirect load direction wrong");
    AST_NONE_IND: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_NONE
        |=> res.indirect_addr[`DAM_BANK_MSB:`DAM_ROW_LSB] ==
            $past(req.m_addr[`DAM_BANK_MSB:`DAM_ROW_LSB]) &&
            res.indirect_addr[`DAM_COL_MSB:`DAM_COL_LSB] == $past(req.r_val))
        else $error("plain indirect address wrong");
    AST_DIAG_IND: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_DIAGONAL && is_transfer(req.op)
        |=> res.indirect_addr[`DAM_BANK_MSB:`DAM_BANK_LSB] == `DAM_PTR_BANK &&
            res.indirect_addr[`DAM_ROW_MSB:`DAM_ROW_LSB] ==
            $past(row_pointer_lower_reg[`DAM_PTRLO_ROW_MSB:0]) &&
            res.indirect_addr[`DAM_COL_MSB:`DAM_COL_LSB] == $past(req.r_val))
        else $error("diagonal indirect address wrong");
    // Only the two transfers follow the pointer; an add keeps the row of m
    AST_DIAG_OTHER: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_DIAGONAL &&
        !is_transfer(req.op)
        |=> res.indirect_addr[`DAM_BANK_MSB:`DAM_ROW_LSB] ==
            $past(req.m_addr[`DAM_BANK_MSB:`DAM_ROW_LSB]))
        else $error("pointer mode moved a non-transfer indirect address");
    AST_DIAG_DIRECT: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_DIAGONAL
        |=> res.direct_addr == $past(req.m_addr))
        else $error("pointer mode touched the direct address");
    AST_INDEX_DIRECT: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_INDEX
        |=> res.direct_addr == ($past(req.m_addr) | $past(index_reg)))
        else $error("index modification of direct address wrong");
    AST_INDEX_IND: assert property (
        req.valid && mode == dam_pkg::DAM_MODE_INDEX
        |=> res.indirect_addr[`DAM_BANK_MSB:`DAM_ROW_LSB] ==
            ($past(req.m_addr[`DAM_BANK_MSB:`DAM_ROW_LSB]) |
             $past({index_upper_field, row_pointer_lower_reg})) &&
            res.indirect_addr[`DAM_COL_MSB:`DAM_COL_LSB] == $past(req.r_val))
        else $error("index modification of indirect address wrong");
    AST_RPE_READ: assert property (
        bus_rd && bus_addr == `DAM_OFS_IDX_UPPER
        |=> bus_rdata[`DAM_RPE_BIT] == $past(row_pointer_enable_flag))
        else $error("pointer enable flag not in upper nibble");
    AST_UPPER_READ: assert property (
        bus_rd && bus_addr == `DAM_OFS_IDX_UPPER
        |=> bus_rdata ==
            $past({row_pointer_enable_flag, index_upper_field}))
        else $error("shared upper nibble readback wrong");
    AST_MIDDLE_READ: assert property (
        bus_rd && bus_addr == `DAM_OFS_IDX_MIDDLE
        |=> bus_rdata == $past(index_middle_field))
        else $error("index middle field readback wrong");
    AST_LOWER_READ: assert property (
        bus_rd && bus_addr == `DAM_OFS_IDX_LOWER
        |=> bus_rdata == $past(index_reg[`DAM_COL_MSB:`DAM_COL_LSB]))
        else $error("index lower field readback wrong");

    COV_INDEX_ADD: cover property (
        req.valid && mode == dam_pkg::DAM_MODE_INDEX &&
        req.op == dam_pkg::DAM_OP_ADD);
    COV_DIAG_STORE: cover property (
        req.valid && mode == dam_pkg::DAM_MODE_DIAGONAL &&
        req.op == dam_pkg::DAM_OP_IND_STORE);
    COV_PLAIN_LOAD: cover property (
        req.valid && mode == dam_pkg::DAM_MODE_NONE &&
        req.op == dam_pkg::DAM_OP_IND_LOAD);
    COV_DIAG_LOAD: cover property (
        req.valid && mode == dam_pkg::DAM_MODE_DIAGONAL &&
        req.op == dam_pkg::DAM_OP_IND_LOAD);
    COV_INDEX_STORE: cover property (
        req.valid && mode == dam_pkg::DAM_MODE_INDEX &&
        req.op == dam_pkg::DAM_OP_IND_STORE);

endmodule : dam_modifier

`default_nettype wire

// ==== bench/testbench.sv ====
/*
 Self-checking bench of the data memory address modifier: register
 port, mode flags and effective address results, directed and random.
 Assumes the design package and module compiled first; no partner.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic mclk, rstn, bus_wr, bus_rd;
    logic [2:0] bus_addr;
    logic [3:0] bus_wdata, bus_rdata;
    logic row_pointer_enable_flag, index_enable_flag;
    dam_pkg::dam_req_t req;
    dam_pkg::dam_res_t res, pend;
    logic [10:0] idx;
    logic rpe, idx_en;
    int err_count, check_count;

    dam_modifier dut (.mclk(mclk), .rstn(rstn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .req(req), .res(res),
        .row_pointer_enable_flag(row_pointer_enable_flag),
        .index_enable_flag(index_enable_flag));

    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    task chk(input string name, input logic [10:0] e, input logic [10:0] g);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    // Mode field reads {index, pointer}; both set reads 3
    function automatic logic [3:0] rd_exp(input logic [2:0] a);
        case (a)
            3'h0: return {rpe, idx[10:8]};
            3'h1: return idx[7:4];
            3'h2: return idx[3:0];
            3'h3: return {1'b0, idx_en, rpe, idx_en};
            default: return 4'h0;
        endcase
    endfunction : rd_exp

    // Both flags set falls back to plain addressing, as the design chose
    function automatic dam_pkg::dam_res_t predict(dam_pkg::dam_req_t q);
        dam_pkg::dam_res_t e;
        logic [10:0] d;
        logic [10:0] ind;
        e = '0;
        d = (idx_en && !rpe) ? (q.m_addr | idx) : q.m_addr;
        ind = (rpe && !idx_en) ? {4'h0, idx[6:4], q.r_val}
                               : {d[10:4], q.r_val};
        e.valid = q.valid;
        e.op = q.op;
        e.direct_addr = d;
        e.indirect_addr = ind;
        e.wr_en = (q.op != dam_pkg::DAM_OP_DATA);
        e.src_addr = (q.op == dam_pkg::DAM_OP_IND_LOAD) ? ind : d;
        e.dst_addr = (q.op == dam_pkg::DAM_OP_IND_STORE) ? ind : d;
        if (q.op == dam_pkg::DAM_OP_ADD)
        begin
            e.dst_addr = q.r_addr;
            {e.carry, e.sum} = {1'b0, q.r_val} + {1'b0, q.m_val};
        end
        return e;
    endfunction : predict

    task chk_res;
        chk("res.valid", 11'(pend.valid), 11'(res.valid));
        if (pend.valid === 1'b1)
        begin
            chk("op", 11'(pend.op), 11'(res.op));
            chk("direct", pend.direct_addr, res.direct_addr);
            chk("wr_en", 11'(pend.wr_en), 11'(res.wr_en));
            chk("dst", pend.dst_addr, res.dst_addr);
            if (pend.op == dam_pkg::DAM_OP_ADD)
                chk("sum", 11'({pend.carry, pend.sum}),
                    11'({res.carry, res.sum}));
            if (pend.op[1] == 1'b1)
            begin
                chk("indirect", pend.indirect_addr, res.indirect_addr);
                chk("src", pend.src_addr, res.src_addr);
            end
        end
    endtask : chk_res

    task wr(input logic [2:0] a, input logic [3:0] d);
        @(posedge mclk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge mclk);
        bus_wr <= 1'b0;
        case (a)
            3'h0: {rpe, idx[10:8]} = d;
            3'h1: idx[7:4] = d;
            3'h2: idx[3:0] = d;
            3'h3: idx_en = d[0];
            default: ;
        endcase
    endtask : wr

    task rd(input logic [2:0] a);
        @(posedge mclk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        chk("bus_rdata", 11'(rd_exp(a)), 11'(bus_rdata));
        chk("flags", 11'({rpe, idx_en}),
            11'({row_pointer_enable_flag, index_enable_flag}));
    endtask : rd

    // Request taken at the next edge; result of the previous one checked
    task issue(input logic v, input dam_pkg::dam_op_t op,
        input logic [10:0] m, input logic [10:0] ra, input logic [3:0] rv);
        dam_pkg::dam_req_t q;
        q = '{v, op, m, ra, rv, 4'($urandom_range(0, 15))};
        @(posedge mclk);
        req <= q;
        #1;
        chk_res();
        pend = predict(q);
    endtask : issue

    task transfers(input logic [10:0] m);
        issue(1'b1, dam_pkg::DAM_OP_ADD, 11'h061, 11'h003, 4'h9);
        issue(1'b1, dam_pkg::DAM_OP_IND_STORE, m, 11'h005, 4'h8);
        issue(1'b1, dam_pkg::DAM_OP_IND_LOAD, m, 11'h00b, 4'he);
        issue(1'b1, dam_pkg::DAM_OP_DATA, 11'h7ff, 11'h000, 4'h0);
        issue(1'b0, dam_pkg::DAM_OP_DATA, 11'h000, 11'h000, 4'h0);
    endtask : transfers

    initial
    begin
        #(50 * 20000);
        err_count++;
        conclude();
    end

    initial
    begin
        {rstn, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
        req = '0;
        pend = '0;
        idx = '0;
        {rpe, idx_en} = 2'b00;
        err_count = 0;
        check_count = 0;
        void'($urandom(79081));
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        for (int a = 0; a < 8; a++)
            rd(3'(a));
        @(posedge mclk);
        #1;
        chk("rdata_idle", 11'h000, 11'(bus_rdata));
        $display("test reset done");
        transfers(11'h034);
        wr(3'h1, 4'he);
        wr(3'h0, 4'hf);
        transfers(11'h034);
        wr(3'h0, 4'h0);
        wr(3'h1, 4'h1);
        wr(3'h2, 4'h2);
        wr(3'h3, 4'h1);
        transfers(11'h034);
        wr(3'h0, 4'h8);
        rd(3'h3);
        transfers(11'h034);
        wr(3'h0, 4'h0);
        $display("test directed done");
        @(posedge mclk);
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        idx = '0;
        {rpe, idx_en} = 2'b00;
        for (int a = 0; a < 4; a++)
            rd(3'(a));
        $display("test mid reset done");
        repeat (300)
        begin
            logic [2:0] a;
            logic [3:0] d;
            a = 3'($urandom_range(0, 7));
            d = 4'($urandom_range(0, 15));
            // Never set both flags: that pairing is unsupported
            if (a == 3'h0 && idx_en)
                d[3] = 1'b0;
            if (a == 3'h3 && rpe)
                d[0] = 1'b0;
            case ($urandom_range(0, 2))
                0: wr(a, d);
                1: rd(a);
                default:
                begin
                    repeat ($urandom_range(1, 4))
                        issue(1'b1, dam_pkg::dam_op_t'($urandom_range(0, 3)),
                            11'($urandom), 11'($urandom), d);
                    issue(1'b0, dam_pkg::DAM_OP_DATA, 11'h0, 11'h0, 4'h0);
                end
            endcase
        end
        $display("test random done");
        conclude();
    end
endmodule : testbench

`default_nettype wire
